// [core/ppc_pkg.sv]
// ppc_pkg: register map, field layout and decode constants of the
// pack protector configuration bank; shared by the bank and its store.
package ppc_pkg;

   // -----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam logic [5:0] NONVOLATILE_ACCESS_STATUS_IDX    = 6'h00;
   localparam logic [5:0] SYSTEM_SETUP_IDX                 = 6'h01;
   localparam logic [5:0] OVERVOLTAGE_THRESHOLD_SETUP_IDX  = 6'h02;
   localparam logic [5:0] OVERVOLTAGE_HYST_DELAY_SETUP_IDX = 6'h03;
   localparam logic [5:0] UNDERVOLTAGE_THRESHOLD_SETUP_IDX = 6'h04;
   localparam logic [5:0] UNDERVOLTAGE_RECOVERY_SETUP_IDX  = 6'h05;
   localparam logic [5:0] DISCHARGE_OVERCURRENT_DELAY_IDX  = 6'h06;
   localparam logic [5:0] DISCHARGE_SHORT_DELAY_IDX        = 6'h07;
   localparam logic [5:0] DISCHARGE_CURRENT_TRIPS_IDX      = 6'h08;
   localparam logic [5:0] CHARGE_SHORT_SETUP_IDX           = 6'h09;
   localparam logic [5:0] BALANCE_SETUP_IDX                = 6'h0a;
   localparam logic [5:0] IRQ_STATUS_IDX                   = 6'h10;
   localparam logic [5:0] IRQ_MASK_IDX                     = 6'h11;
   localparam int         REG_COUNT                        = 11;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int SUPPLY_OK_BIT           = 0;
   localparam int SERIES_CELL_COUNT_LSB   = 5;
   localparam int CHARGER_THERMAL_BYPASS  = 4;
   localparam int TEMP_SENSE_ON_BIT       = 3;
   localparam int OVERTEMP_RECOVERY_BIT   = 2;
   localparam int RESERVED_ZERO_BIT       = 1;
   localparam int OVERCURRENT_RECOVERY    = 0;
   localparam int OV_TRIP_CODE_LSB        = 0;

   // -----------------------------------------------------------------
   // reset values and decode constants
   // -----------------------------------------------------------------
   localparam logic [7:0]  NV_RESET        = 8'h00;
   localparam logic [3:0]  IRQ_MASK_RESET  = 4'h0;
   localparam logic [2:0]  CELL_CODE_BAD   = 3'h7;
   localparam logic [3:0]  CELL_COUNT_MAX  = 4'ha;
   localparam logic [12:0] OV_BASE_MV      = 13'haf0;
   localparam logic [12:0] OV_STEP_MV      = 13'h019;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // interrupt status bit positions
   localparam int EV_OT_SET    = 0;
   localparam int EV_OT_CLEAR  = 1;
   localparam int EV_CELL_BAD  = 2;
   localparam int EV_SUPPLY    = 3;

endpackage

// [core/ppc_store.sv]
// ppc_store: eleven byte locations of the configuration bank.
// assumes the caller decodes addresses; index 0 is never written here.
`timescale 1ns/1ps
module ppc_store
   import ppc_pkg::*;
(
   // clock, reset, enable
   input  wire logic       i_core_clk,
   input  wire logic       i_srst,
   input  wire logic       i_ce,
   // write port
   input  wire logic       i_wr_en,
   input  wire logic [3:0] i_wr_idx,
   input  wire logic [7:0] i_wr_data,
   // read port, data one cycle later
   input  wire logic [3:0] i_rd_idx,
   output logic      [7:0] o_rd_data,
   // live fields for decode
   output logic      [7:0] o_system_setup,
   output logic      [7:0] o_ov_threshold
);

   typedef struct packed {
      logic [REG_COUNT-1:0][7:0] mem;
      logic [7:0]                rd;
   } ppc_store_t;

   ppc_store_t r;
   ppc_store_t next_r;

   always_comb
   begin
      next_r = r;
      if (i_wr_en && (i_wr_idx < 4'(REG_COUNT)))
      begin
         next_r.mem[i_wr_idx] = i_wr_data;
      end
      next_r.rd = (i_rd_idx < 4'(REG_COUNT)) ? r.mem[i_rd_idx] : 8'h00;
   end

   // nonvolatile contents come up as the blank value after reset
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         r <= '{mem: {REG_COUNT{NV_RESET}}, rd: 8'h00};
      end
      else if (i_ce)
      begin
         r <= next_r;
      end
   end

   assign o_rd_data      = r.rd;
   assign o_system_setup = r.mem[SYSTEM_SETUP_IDX[3:0]];
   assign o_ov_threshold = r.mem[OVERVOLTAGE_THRESHOLD_SETUP_IDX[3:0]];

endmodule

// [core/ppc_bank.sv]
// ppc_bank: configuration bank of a multi-cell pack protector, reached
// over AXI4-Lite, with thermal fault policy and field decode.
// assumes a synchronous AXI4-Lite master on i_core_clk; bus quiet while
// i_ce is low.
`timescale 1ns/1ps
module ppc_bank
   import ppc_pkg::*;
(
   // clock, reset, enable
   input  wire logic        i_core_clk,
   input  wire logic        i_srst,
   input  wire logic        i_ce,
   // axi4-lite write address and data
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   // axi4-lite write response
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic      [1:0]  o_bresp,
   // axi4-lite read
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [7:0]  i_araddr,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic      [31:0] o_rdata,
   output logic      [1:0]  o_rresp,
   // pack conditions
   input  wire logic        i_supply_ok,
   input  wire logic        i_charger_present,
   input  wire logic        i_load_present,
   input  wire logic        i_temp_over,
   input  wire logic        i_temp_cool,
   // decoded settings and status
   output logic      [3:0]  o_series_cell_count,
   output logic             o_cfg_bad,
   output logic      [12:0] o_ov_trip_mv,
   output logic             o_temp_sense_on,
   output logic             o_thermal_active,
   output logic             o_overcurrent_recovery_sel,
   output logic             o_overtemp_fault,
   output logic             o_irq
);

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [5:0] word_idx(input logic [7:0] addr);
      return addr[7:2];
   endfunction

   function automatic logic is_store(input logic [5:0] idx);
      return (idx >= SYSTEM_SETUP_IDX) && (idx <= BALANCE_SETUP_IDX);
   endfunction

   function automatic logic is_mapped(input logic [5:0] idx);
      return (idx <= BALANCE_SETUP_IDX) || (idx == IRQ_STATUS_IDX)
             || (idx == IRQ_MASK_IDX);
   endfunction

   function automatic logic [3:0] cell_count_of(input logic [2:0] code);
      return (code == CELL_CODE_BAD) ? 4'h0 : CELL_COUNT_MAX - {1'b0, code};
   endfunction

   function automatic logic [12:0] ov_mv_of(input logic [5:0] code);
      return OV_BASE_MV + 13'(OV_STEP_MV * {7'h00, code});
   endfunction

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic        aw_full;
      logic [5:0]  aw_idx;
      logic        w_full;
      logic [7:0]  w_data;
      logic        w_low;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rd_pend;
      logic [5:0]  rd_idx;
      logic        rvalid;
      logic [7:0]  rdata;
      logic [1:0]  rresp;
      logic        supply_q;
      logic [3:0]  stat;
      logic [3:0]  mask;
      logic        irq;
      logic [3:0]  cells;
      logic        cfg_bad;
      logic [12:0] ov_mv;
      logic        sense_on;
      logic        thermal_active;
      logic        oc_rec;
      logic        ot_fault;
   } ppc_bank_t;

   ppc_bank_t   r;
   ppc_bank_t   next_r;
   logic        wr_fire;
   logic        st_wr;
   logic [7:0]  st_rd;
   logic [7:0]  sys;
   logic [7:0]  ovc;
   logic [2:0]  cell_code;
   logic        bypass;
   logic        charger_clears;

   assign cell_code      = sys[SERIES_CELL_COUNT_LSB +: 3];
   assign bypass         = sys[CHARGER_THERMAL_BYPASS];
   assign charger_clears = bypass && i_charger_present;
   assign wr_fire        = r.aw_full && r.w_full && !r.bvalid;
   // index 0 is never stored, so its read-only bit cannot be written
   assign st_wr          = wr_fire && r.w_low && is_store(r.aw_idx);

   ppc_store u_store (
      .i_core_clk     (i_core_clk),
      .i_srst         (i_srst),
      .i_ce           (i_ce),
      .i_wr_en        (st_wr),
      .i_wr_idx       (r.aw_idx[3:0]),
      .i_wr_data      (r.w_data),
      .i_rd_idx       (word_idx(i_araddr) < 6'h10 ? i_araddr[5:2] : 4'hf),
      .o_rd_data      (st_rd),
      .o_system_setup (sys),
      .o_ov_threshold (ovc)
   );

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb
   begin
      logic [3:0] ev;
      logic [3:0] clr;
      ev     = 4'h0;
      clr    = 4'h0;
      next_r = r;

      // write channels are taken in either order
      if (i_awvalid && r.awready)
      begin
         next_r.aw_full = 1'b1;
         next_r.aw_idx  = word_idx(i_awaddr);
      end
      if (i_wvalid && r.wready)
      begin
         next_r.w_full = 1'b1;
         next_r.w_data = i_wdata[7:0];
         next_r.w_low  = i_wstrb[0];
      end
      if (wr_fire)
      begin
         next_r.aw_full = 1'b0;
         next_r.w_full  = 1'b0;
         next_r.bvalid  = 1'b1;
         next_r.bresp   = is_mapped(r.aw_idx) ? RESP_OKAY : RESP_SLVERR;
         if (r.w_low && r.aw_idx == IRQ_STATUS_IDX)
         begin
            clr = r.w_data[3:0];
         end
         if (r.w_low && r.aw_idx == IRQ_MASK_IDX)
         begin
            next_r.mask = r.w_data[3:0];
         end
      end
      if (r.bvalid && i_bready)
      begin
         next_r.bvalid = 1'b0;
      end
      next_r.awready = !next_r.aw_full;
      next_r.wready  = !next_r.w_full;

      // read: store answers one cycle after the address is taken
      if (i_arvalid && r.arready)
      begin
         next_r.rd_pend = 1'b1;
         next_r.rd_idx  = word_idx(i_araddr);
      end
      if (r.rd_pend)
      begin
         next_r.rd_pend = 1'b0;
         next_r.rvalid  = 1'b1;
         next_r.rresp   = is_mapped(r.rd_idx) ? RESP_OKAY : RESP_SLVERR;
         if (r.rd_idx == NONVOLATILE_ACCESS_STATUS_IDX)
         begin
            next_r.rdata = {7'h00, r.supply_q};
         end
         else if (is_store(r.rd_idx))
         begin
            next_r.rdata = st_rd;
         end
         else if (r.rd_idx == IRQ_STATUS_IDX)
         begin
            next_r.rdata = {4'h0, r.stat};
         end
         else if (r.rd_idx == IRQ_MASK_IDX)
         begin
            next_r.rdata = {4'h0, r.mask};
         end
         else
         begin
            next_r.rdata = 8'h00;
         end
      end
      if (r.rvalid && i_rready)
      begin
         next_r.rvalid = 1'b0;
      end
      next_r.arready = !next_r.rd_pend && !next_r.rvalid;

      // decode uses only the named fields, reserved bits drop out
      next_r.cells   = cell_count_of(cell_code);
      next_r.cfg_bad = (cell_code == CELL_CODE_BAD);
      next_r.ov_mv   = ov_mv_of(ovc[OV_TRIP_CODE_LSB +: 6]);
      next_r.sense_on = sys[TEMP_SENSE_ON_BIT];
      next_r.oc_rec   = sys[OVERCURRENT_RECOVERY];
      next_r.thermal_active = sys[TEMP_SENSE_ON_BIT] && !charger_clears;

      // thermal fault: charger clear beats the recovery choice
      if (charger_clears || !sys[TEMP_SENSE_ON_BIT])
      begin
         next_r.ot_fault = 1'b0;
      end
      else if (!r.ot_fault)
      begin
         next_r.ot_fault = i_temp_over;
      end
      else if (i_temp_cool && (!sys[OVERTEMP_RECOVERY_BIT] || !i_load_present))
      begin
         next_r.ot_fault = 1'b0;
      end

      next_r.supply_q = i_supply_ok;
      ev[EV_OT_SET]   = next_r.ot_fault && !r.ot_fault;
      ev[EV_OT_CLEAR] = !next_r.ot_fault && r.ot_fault;
      ev[EV_CELL_BAD] = next_r.cfg_bad && !r.cfg_bad;
      ev[EV_SUPPLY]   = i_supply_ok != r.supply_q;
      // an event in the clearing cycle survives the clear
      next_r.stat = (r.stat & ~clr) | ev;
      next_r.irq  = |(next_r.stat & next_r.mask);
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         r         <= '0;
         r.mask    <= IRQ_MASK_RESET;
         r.awready <= 1'b1;
         r.wready  <= 1'b1;
         r.arready <= 1'b1;
         r.ov_mv   <= OV_BASE_MV;
         r.cells   <= CELL_COUNT_MAX;
      end
      else if (i_ce)
      begin
         r <= next_r;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign o_awready                 = r.awready;
   assign o_wready                  = r.wready;
   assign o_bvalid                  = r.bvalid;
   assign o_bresp                   = r.bresp;
   assign o_arready                 = r.arready;
   assign o_rvalid                  = r.rvalid;
   assign o_rdata                   = {24'h000000, r.rdata};
   assign o_rresp                   = r.rresp;
   assign o_series_cell_count       = r.cells;
   assign o_cfg_bad                 = r.cfg_bad;
   assign o_ov_trip_mv              = r.ov_mv;
   assign o_temp_sense_on           = r.sense_on;
   assign o_thermal_active          = r.thermal_active;
   assign o_overcurrent_recovery_sel = r.oc_rec;
   assign o_overtemp_fault          = r.ot_fault;
   assign o_irq                     = r.irq;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_srst);

   read_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read answer dropped");
   status_read_a: assert property (i_ce && r.rd_pend && r.rd_idx == 6'h00
      |=> o_rdata == {31'h0, $past(r.supply_q)})
      else $error("access byte read wrong");
   ov_decode_a: assert property (i_ce
      |=> o_ov_trip_mv == 13'(13'd2800 + 13'd25 * $past(ovc[5:0])))
      else $error("trip voltage decode wrong");
   cell_decode_a: assert property (i_ce && cell_code != 3'h7
      |=> o_series_cell_count == 4'(4'd10 - $past(cell_code)))
      else $error("cell count decode wrong");
   bad_code_a: assert property (i_ce && cell_code == 3'h7
      |=> o_cfg_bad && o_series_cell_count == 4'h0)
      else $error("forbidden cell code not flagged");
   charger_clear_a: assert property (i_ce && bypass && i_charger_present
      |=> !o_overtemp_fault && !o_thermal_active)
      else $error("charger did not clear thermal fault");
   sense_off_a: assert property (i_ce && !sys[3] |=> !o_overtemp_fault)
      else $error("fault with sensing off");
   load_hold_a: assert property (o_overtemp_fault && i_ce && sys[2] && sys[3]
      && i_load_present && !charger_clears |=> o_overtemp_fault)
      else $error("fault ended with load present");
   ot_event_a: assert property (i_ce && !o_overtemp_fault ##1 i_ce && o_overtemp_fault
      |-> r.stat[0])
      else $error("fault event not latched");
   fault_set_a: assert property (i_ce && !o_overtemp_fault && sys[3] && !charger_clears
      && i_temp_over |=> o_overtemp_fault)
      else $error("hot pack raised no fault");
   fall_event_a: assert property (i_ce && o_overtemp_fault ##1 i_ce && !o_overtemp_fault
      |-> r.stat[1])
      else $error("fault end event not latched");
   supply_event_a: assert property (i_ce && i_supply_ok != r.supply_q |=> r.stat[3])
      else $error("supply change not latched");
   ro_write_a: assert property (i_ce && wr_fire && r.aw_idx == 6'h00
      |=> o_bvalid && o_bresp == RESP_OKAY)
      else $error("access byte write refused");
   aw_taken_a: assert property (i_ce && i_awvalid && o_awready |=> !o_awready)
      else $error("address slot not closed");
   rd_answer_a: assert property (i_ce && i_arvalid && o_arready ##1 i_ce |=> o_rvalid)
      else $error("read answer late");
   wr_answer_a: assert property (i_ce && i_awvalid && o_awready && i_wvalid && o_wready
      ##1 i_ce && !o_bvalid |=> o_bvalid)
      else $error("write answer late");

endmodule

// [dv/ppc_host.sv]
// ppc_host: axi4-lite master standing in for the programming host.
// assumes one bench process calls its tasks; tmo flags a lost answer.
`timescale 1ns/1ps
module ppc_host
   import ppc_pkg::*;
(
   // clock
   input  wire logic        i_core_clk,
   // write channels
   output logic             o_awvalid,
   input  wire logic        i_awready,
   output logic      [7:0]  o_awaddr,
   output logic             o_wvalid,
   input  wire logic        i_wready,
   output logic      [31:0] o_wdata,
   output logic      [3:0]  o_wstrb,
   input  wire logic        i_bvalid,
   output logic             o_bready,
   input  wire logic [1:0]  i_bresp,
   // read channels
   output logic             o_arvalid,
   input  wire logic        i_arready,
   output logic      [7:0]  o_araddr,
   input  wire logic        i_rvalid,
   output logic             o_rready,
   input  wire logic [31:0] i_rdata,
   input  wire logic [1:0]  i_rresp
);
   bit tmo = 1'b0;
   initial
   begin
      {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
      {o_awaddr, o_araddr, o_wdata, o_wstrb} = 52'h0;
   end

   task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] s,
                     output logic [1:0] resp);
      int n;
      @(posedge i_core_clk);
      n = 0;
      resp = 2'h3;
      o_awaddr  <= {idx, 2'b00};
      // reserved bit 1 of system setup always goes out as zero
      o_wdata   <= {24'h0, (idx == SYSTEM_SETUP_IDX) ? (d & 8'hfd) : d};
      o_wstrb   <= s;
      o_awvalid <= 1'b1;
      o_wvalid  <= 1'b1;
      o_bready  <= 1'b1;
      while (n < 100)
      begin
         @(posedge i_core_clk);
         n++;
         if (o_awvalid && i_awready) o_awvalid <= 1'b0;
         if (o_wvalid && i_wready) o_wvalid <= 1'b0;
         if (o_bready && i_bvalid)
         begin
            resp = i_bresp;
            o_bready <= 1'b0;
            n = 1000;
         end
      end
      if (n != 1000) tmo = 1'b1;
   endtask

   task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp);
      int n;
      @(posedge i_core_clk);
      n = 0;
      d = '1;
      resp = 2'h3;
      o_araddr  <= {idx, 2'b00};
      o_arvalid <= 1'b1;
      o_rready  <= 1'b1;
      while (n < 100)
      begin
         @(posedge i_core_clk);
         n++;
         if (o_arvalid && i_arready) o_arvalid <= 1'b0;
         if (o_rready && i_rvalid)
         begin
            d = i_rdata;
            resp = i_rresp;
            o_rready <= 1'b0;
            n = 1000;
         end
      end
      if (n != 1000) tmo = 1'b1;
   endtask
endmodule

// [dv/ppc_bank_tb.sv]
// ppc_bank_tb: self-checking bench of the configuration bank.
// assumes ppc_host as bus master; pack conditions driven here.
`timescale 1ns/1ps
module ppc_bank_tb;
   import ppc_pkg::*;
   logic clk = 0, srst = 1, aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
   logic [7:0] aw_a, ar_a;
   logic [31:0] w_d, r_d;
   logic [3:0] w_s, cells;
   logic [1:0] b_resp, r_resp;
   logic supply = 0, charger = 0, load = 0, over = 0, cool = 0, ce = 1;
   logic bad, sense, active, ocsel, fault, irq;
   logic [12:0] ovmv;
   int err_count = 0, checks = 0;

   always #20 clk = ~clk;

   ppc_host u_host (.i_core_clk(clk), .o_awvalid(aw_v), .i_awready(aw_r), .o_awaddr(aw_a),
      .o_wvalid(w_v), .i_wready(w_r), .o_wdata(w_d), .o_wstrb(w_s), .i_bvalid(b_v),
      .o_bready(b_r), .i_bresp(b_resp), .o_arvalid(ar_v), .i_arready(ar_r),
      .o_araddr(ar_a), .i_rvalid(r_v), .o_rready(r_r), .i_rdata(r_d), .i_rresp(r_resp));

   ppc_bank dut (.i_core_clk(clk), .i_srst(srst), .i_ce(ce), .i_awvalid(aw_v),
      .o_awready(aw_r), .i_awaddr(aw_a), .i_wvalid(w_v), .o_wready(w_r), .i_wdata(w_d),
      .i_wstrb(w_s), .o_bvalid(b_v), .i_bready(b_r), .o_bresp(b_resp), .i_arvalid(ar_v),
      .o_arready(ar_r), .i_araddr(ar_a), .o_rvalid(r_v), .i_rready(r_r), .o_rdata(r_d),
      .o_rresp(r_resp), .i_supply_ok(supply), .i_charger_present(charger),
      .i_load_present(load), .i_temp_over(over), .i_temp_cool(cool),
      .o_series_cell_count(cells), .o_cfg_bad(bad), .o_ov_trip_mv(ovmv),
      .o_temp_sense_on(sense), .o_thermal_active(active),
      .o_overcurrent_recovery_sel(ocsel), .o_overtemp_fault(fault), .o_irq(irq));

   // ---------------------------------------------------------------
   // shared helpers
   // ---------------------------------------------------------------
   task automatic end_of_test;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrc(input logic [5:0] i, input logic [7:0] d, input logic [3:0] s,
                      input logic [1:0] er);
      logic [1:0] r;
      u_host.wr(i, d, s, r);
      cmp({30'h0, r}, {30'h0, er});
      if (u_host.tmo)
      begin
         err_count++;
         end_of_test();
      end
   endtask

   task automatic rdc(input logic [5:0] i, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      u_host.rd(i, d, r);
      cmp(d, e);
      cmp({30'h0, r}, {30'h0, er});
      if (u_host.tmo)
      begin
         err_count++;
         end_of_test();
      end
   endtask

   // decoded outputs lag by one edge; three edges leave margin
   task automatic pk(input logic [3:0] v, input logic ef, input logic ea);
      @(posedge clk);
      {charger, load, over, cool} <= v;
      repeat (3) @(posedge clk);
      cmp({31'h0, fault}, {31'h0, ef});
      cmp({31'h0, active}, {31'h0, ea});
   endtask

   function automatic logic [7:0] pat(input int i);
      return {i[3:0], ~i[3:0]};
   endfunction

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      cmp({28'h0, cells}, 32'ha);
      cmp({19'h0, ovmv}, 32'haf0);
      for (int i = 0; i < REG_COUNT; i++) rdc(i[5:0], 32'h0, RESP_OKAY);
      $display("test reset done");
   endtask

   task automatic t_map;
      for (int i = 1; i < REG_COUNT; i++) wrc(i[5:0], pat(i), 4'h1, RESP_OKAY);
      for (int i = 1; i < REG_COUNT; i++)
         rdc(i[5:0], {24'h0, pat(i) & ((i == 1) ? 8'hfd : 8'hff)}, RESP_OKAY);
      wrc(NONVOLATILE_ACCESS_STATUS_IDX, 8'hff, 4'h1, RESP_OKAY);
      rdc(NONVOLATILE_ACCESS_STATUS_IDX, 32'h0, RESP_OKAY);
      wrc(DISCHARGE_CURRENT_TRIPS_IDX, 8'h00, 4'h0, RESP_OKAY);
      rdc(DISCHARGE_CURRENT_TRIPS_IDX, {24'h0, pat(8)}, RESP_OKAY);
      wrc(6'h0b, 8'h77, 4'h1, RESP_SLVERR);
      rdc(6'h0b, 32'h0, RESP_SLVERR);
      rdc(BALANCE_SETUP_IDX, {24'h0, pat(10)}, RESP_OKAY);
      $display("test map done");
   endtask

   task automatic t_cells;
      for (int c = 0; c < 8; c++)
      begin
         wrc(SYSTEM_SETUP_IDX, {c[2:0], 5'h00}, 4'h1, RESP_OKAY);
         repeat (2) @(posedge clk);
         cmp({28'h0, cells}, (c == 7) ? 32'h0 : 32'(10 - c));
         cmp({31'h0, bad}, {31'h0, c == 7});
      end
      $display("test cells done");
   endtask

   task automatic t_ov;
      logic [5:0] codes [4] = '{6'h00, 6'h01, 6'h20, 6'h3f};
      foreach (codes[k])
      begin
         wrc(OVERVOLTAGE_THRESHOLD_SETUP_IDX, {2'b11, codes[k]}, 4'h1, RESP_OKAY);
         repeat (2) @(posedge clk);
         cmp({19'h0, ovmv}, 32'(2800 + 25 * codes[k]));
      end
      $display("test trip done");
   endtask

   task automatic t_therm;
      wrc(SYSTEM_SETUP_IDX, 8'h09, 4'h1, RESP_OKAY);
      pk(4'b1010, 1'b1, 1'b1);
      cmp({30'h0, sense, ocsel}, 32'h3);
      pk(4'b1001, 1'b0, 1'b1);
      wrc(SYSTEM_SETUP_IDX, 8'h0c, 4'h1, RESP_OKAY);
      pk(4'b0110, 1'b1, 1'b1);
      pk(4'b0101, 1'b1, 1'b1);
      pk(4'b0001, 1'b0, 1'b1);
      wrc(SYSTEM_SETUP_IDX, 8'h1c, 4'h1, RESP_OKAY);
      pk(4'b0110, 1'b1, 1'b1);
      pk(4'b1110, 1'b0, 1'b0);
      wrc(SYSTEM_SETUP_IDX, 8'h00, 4'h1, RESP_OKAY);
      pk(4'b0010, 1'b0, 1'b0);
      cmp({30'h0, sense, ocsel}, 32'h0);
      $display("test thermal done");
   endtask

   task automatic t_irq;
      wrc(IRQ_STATUS_IDX, 8'h0f, 4'h1, RESP_OKAY);
      rdc(IRQ_STATUS_IDX, 32'h0, RESP_OKAY);
      @(posedge clk);
      supply <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(IRQ_STATUS_IDX, 32'h8, RESP_OKAY);
      rdc(NONVOLATILE_ACCESS_STATUS_IDX, 32'h1, RESP_OKAY);
      cmp({31'h0, irq}, 32'h0);
      wrc(IRQ_MASK_IDX, 8'h08, 4'h1, RESP_OKAY);
      repeat (2) @(posedge clk);
      cmp({31'h0, irq}, 32'h1);
      wrc(IRQ_STATUS_IDX, 8'h08, 4'h1, RESP_OKAY);
      repeat (2) @(posedge clk);
      cmp({31'h0, irq}, 32'h0);
      rdc(IRQ_MASK_IDX, 32'h8, RESP_OKAY);
      $display("test irq done");
   endtask

   // enable low must hold back a supply change until enable returns; then a mid-run reset clears the store
   task automatic t_ce;
      @(posedge clk);
      ce     <= 1'b0;
      supply <= 1'b0;
      repeat (3) @(posedge clk);
      cmp({31'h0, irq}, 32'h0);
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      cmp({31'h0, irq}, 32'h1);
      wrc(IRQ_STATUS_IDX, 8'h08, 4'h1, RESP_OKAY);
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      cmp({28'h0, cells}, 32'ha);
      cmp({19'h0, ovmv}, 32'haf0);
      cmp({31'h0, irq}, 32'h0);
      rdc(OVERVOLTAGE_THRESHOLD_SETUP_IDX, 32'h0, RESP_OKAY);
      rdc(IRQ_MASK_IDX, 32'h0, RESP_OKAY);
      $display("test enable and reset done");
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_map();
      t_cells();
      t_ov();
      t_therm();
      t_irq();
      t_ce();
      end_of_test();
   end
endmodule
